// [hdl/smpc_cfg.svh]
// Register offsets, field positions, reset values and timing figures of the pulse controller.
// Assumes it is included by bare name from every file that needs a constant.
`ifndef SMPC_CFG_SVH
`define SMPC_CFG_SVH

// Register bus geometry.
`define SMPC_ADDR_W 9
`define SMPC_DATA_W 8
`define SMPC_OFS_TIMING 9'h111
`define SMPC_OFS_MODE 9'h112
`define SMPC_OFS_STATUS 9'h113
`define SMPC_RST_TIMING 8'h00
`define SMPC_RST_MODE 8'h00
`define SMPC_READ_ZERO 8'h00

// Timing control fields.
`define SMPC_DIV_HI 7
`define SMPC_DIV_LO 6
`define SMPC_MIN_HI 5
`define SMPC_MIN_LO 4
`define SMPC_MAX_HI 3
`define SMPC_MAX_LO 2
`define SMPC_FIX_HI 1
`define SMPC_FIX_LO 0

// Mode control fields; bit 4 is unimplemented and reads as zero.
`define SMPC_BIT_ENABLE 7
`define SMPC_BIT_POL_A 6
`define SMPC_BIT_POL_B 5
`define SMPC_BIT_UNUSED 4
`define SMPC_BIT_RAMP 3
`define SMPC_BIT_DUAL 2
`define SMPC_BIT_PWM 1
`define SMPC_BIT_BOTH 0

// Status fields.
`define SMPC_STS_ACTIVE 0
`define SMPC_STS_SECOND 1
`define SMPC_STS_FEEDBACK 2
`define SMPC_STS_ENABLED 3

// Period counter: last count of each period, for divide by 128, 64, 32, 16.
`define SMPC_CNT_W 7
`define SMPC_LAST_128 7'h7F
`define SMPC_LAST_64 7'h3F
`define SMPC_LAST_32 7'h1F
`define SMPC_LAST_16 7'h0F
`define SMPC_CNT_ONE 7'h01
`define SMPC_CNT_ZERO 7'h00

// Duty points counted in sixteenths of the period.
`define SMPC_PH_W 4
`define SMPC_PH_0 4'h0
`define SMPC_PH_2 4'h2
`define SMPC_PH_4 4'h4
`define SMPC_PH_6 4'h6
`define SMPC_PH_8 4'h8
`define SMPC_PH_10 4'hA
`define SMPC_PH_12 4'hC
`define SMPC_PH_15 4'hF

`endif

// [hdl/smpc_pkg.sv]
// Types shared by the pulse controller files.
// Assumes the constant header is compiled alongside it.
package smpc_pkg;

  // Pulse sequencer states.
  typedef enum logic [1:0] {
    SMPC_OFF,
    SMPC_WAIT,
    SMPC_ON
  } smpc_pulse_t;

  // Period divider codes.
  typedef logic [1:0] smpc_sel_t;

endpackage

// [hdl/smpc_period_timer.sv]
// Free-running period counter of the pulse controller.
// Assumes one clock, a synchronous active-low reset and a stable divider while running.
`timescale 1ns/1ps
`include "smpc_cfg.svh"

module smpc_period_timer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  input wire smpc_pkg::smpc_sel_t divSel,
  output logic lastCyc,
  output logic [`SMPC_PH_W-1:0] nextPhase
);

  logic [`SMPC_CNT_W-1:0] count_q;
  logic [`SMPC_CNT_W-1:0] count_d;
  logic [`SMPC_CNT_W-1:0] lastCount;

  // Last count of the period for the chosen divider.
  function automatic logic [`SMPC_CNT_W-1:0] last_of(input smpc_pkg::smpc_sel_t sel);
    case (sel)
      2'h0: last_of = `SMPC_LAST_128;
      2'h1: last_of = `SMPC_LAST_64;
      2'h2: last_of = `SMPC_LAST_32;
      default: last_of = `SMPC_LAST_16;
    endcase
  endfunction

  // Sixteenth of the period that a count falls in.
  function automatic logic [`SMPC_PH_W-1:0] phase_of(input logic [`SMPC_CNT_W-1:0] cnt,
                                                      input smpc_pkg::smpc_sel_t sel);
    case (sel)
      2'h0: phase_of = cnt[6:3];
      2'h1: phase_of = cnt[5:2];
      2'h2: phase_of = cnt[4:1];
      default: phase_of = cnt[3:0];
    endcase
  endfunction

  // The compare is at-or-above so a divider change cannot run the count away.
  always_comb begin
    lastCount = last_of(divSel);
    lastCyc = run && (count_q >= lastCount);
    count_d = lastCyc ? `SMPC_CNT_ZERO : count_q + `SMPC_CNT_ONE;
    nextPhase = phase_of(count_d, divSel);
  end

  // The count runs on every system clock while enabled and rests at zero otherwise.
  always_ff @(posedge mclk) begin
    if (!nrst || !run) begin
      count_q <= `SMPC_CNT_ZERO;
    end else begin
      count_q <= count_d; // [RULE24] [RULE25]
    end
  end

endmodule

// [hdl/smpc_controller.sv]
// Switch-mode pulse controller: registers, pulse sequencer and the two pulse pins.
// Assumes synchronous comparator inputs and a master that keeps the strobe protocol.
//
// Contract
// RULE1 - Pulse-skip samples feedback just before each start.
// RULE2 - High sample gives fixed pulse; low skips.
// RULE3 - Both comparators selected: both must be high.
// RULE4 - Started skip pulse ignores feedback until duty.
// RULE5 - Single mode pulses primary only within limits.
// RULE6 - Dual mode alternates pulses between both outputs.
// RULE7 - Dual mode duty never exceeds half period.
// RULE8 - Ramp switch pulls secondary low last sixteenth.
// RULE9 - Ramp switch ignores secondary polarity.
// RULE10 - Outputs float after reset until configured.
// RULE11 - Divider field selects period of 128..16 clocks.
// RULE12 - Software stops controller before changing divider.
// RULE13 - Minimum duty field gives 0..3/8 forced time.
// RULE14 - Maximum duty field gives 1/2..15/16 cutoff.
// RULE15 - Fixed duty field gives 1/8..15/16 skip width.
// RULE16 - Controller runs only while enable bit set.
// RULE17 - Modulation bit picks width or skip mode.
// RULE18 - Input bit selects one or both comparators.
// RULE19 - Output-mode bit selects dual or single output.
// RULE20 - Polarity bit set makes output active low.
// RULE21 - Ramp enable only acts in single mode.
// RULE22 - Software clears port direction bits for pins.
// RULE23 - Width mode ends on falling feedback or maximum.
// RULE24 - All timing derives from the system clock.
// RULE25 - Free counter compared against decoded duty points.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "smpc_cfg.svh"

module smpc_controller (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [`SMPC_ADDR_W-1:0] regAddr,
  input wire logic [`SMPC_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`SMPC_DATA_W-1:0] regRdData_q,
  input wire logic firstComparatorResult,
  input wire logic secondComparatorResult,
  output logic primaryPulseOut_q,
  output logic primaryPulseOeN_q,
  output logic secondaryPulseOut_q,
  output logic secondaryPulseOeN_q
);

  logic [`SMPC_DATA_W-1:0] pulseTimingControl_q;
  logic [`SMPC_DATA_W-1:0] pulseModeControl_q;
  smpc_pkg::smpc_pulse_t state_q;
  smpc_pkg::smpc_pulse_t state_d;
  logic toSecond_q;
  logic toSecond_d;
  logic feedbackPrev_q;
  logic feedback;
  logic feedbackFall;
  logic startOk;
  logic pulseActive;
  logic lastCyc;
  logic [`SMPC_PH_W-1:0] nextPhase;
  logic moduleEnable;
  logic modulationSelect;
  logic feedbackInputSelect;
  logic outputMode;
  logic rampSwitchActive;
  logic [`SMPC_PH_W-1:0] minPoint;
  logic [`SMPC_PH_W-1:0] maxPoint;
  logic [`SMPC_PH_W-1:0] fixedPoint;
  logic [`SMPC_DATA_W-1:0] statusWord;

  // Minimum duty point in sixteenths.
  function automatic logic [`SMPC_PH_W-1:0] min_point(input logic [1:0] code);
    case (code)
      2'h0: min_point = `SMPC_PH_0;
      2'h1: min_point = `SMPC_PH_2;
      2'h2: min_point = `SMPC_PH_4;
      default: min_point = `SMPC_PH_6;
    endcase
  endfunction

  // Maximum duty point in sixteenths.
  function automatic logic [`SMPC_PH_W-1:0] max_point(input logic [1:0] code);
    case (code)
      2'h0: max_point = `SMPC_PH_8;
      2'h1: max_point = `SMPC_PH_10;
      2'h2: max_point = `SMPC_PH_12;
      default: max_point = `SMPC_PH_15;
    endcase
  endfunction

  // Fixed pulse-skip duty point in sixteenths.
  function automatic logic [`SMPC_PH_W-1:0] fixed_point(input logic [1:0] code);
    case (code)
      2'h0: fixed_point = `SMPC_PH_2;
      2'h1: fixed_point = `SMPC_PH_6;
      2'h2: fixed_point = `SMPC_PH_10;
      default: fixed_point = `SMPC_PH_15;
    endcase
  endfunction

  // Field decode of the two control registers.
  assign moduleEnable = pulseModeControl_q[`SMPC_BIT_ENABLE]; // [RULE16]
  assign modulationSelect = pulseModeControl_q[`SMPC_BIT_PWM]; // [RULE17]
  assign feedbackInputSelect = pulseModeControl_q[`SMPC_BIT_BOTH];
  assign outputMode = pulseModeControl_q[`SMPC_BIT_DUAL];
  assign rampSwitchActive = pulseModeControl_q[`SMPC_BIT_RAMP] && !outputMode; // [RULE21]
  assign minPoint = min_point(pulseTimingControl_q[`SMPC_MIN_HI:`SMPC_MIN_LO]); // [RULE13]
  assign maxPoint = max_point(pulseTimingControl_q[`SMPC_MAX_HI:`SMPC_MAX_LO]); // [RULE14]
  assign fixedPoint = fixed_point(pulseTimingControl_q[`SMPC_FIX_HI:`SMPC_FIX_LO]); // [RULE15]

  // Period counter; the divider is taken as steady while the block runs.
  smpc_period_timer periodTimer (
    .mclk(mclk),
    .nrst(nrst),
    .run(moduleEnable),
    .divSel(pulseTimingControl_q[`SMPC_DIV_HI:`SMPC_DIV_LO]), // [RULE11] [RULE12]
    .lastCyc(lastCyc),
    .nextPhase(nextPhase)
  );

  // Feedback is the first comparator, or both anded when selected.
  assign feedback = firstComparatorResult &&
                    (secondComparatorResult || !feedbackInputSelect); // [RULE18] [RULE3]
  assign feedbackFall = feedbackPrev_q && !feedback;

  // Start decision taken in the last cycle of the period before.
  always_comb begin
    if (modulationSelect) begin
      startOk = (minPoint != `SMPC_PH_0) || feedback;
    end else begin
      startOk = feedback; // [RULE1] [RULE2]
    end
  end

  // Pulse sequencer: decides whether the pulse stands in the coming cycle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      smpc_pkg::SMPC_OFF: begin
        if (moduleEnable) begin
          state_d = smpc_pkg::SMPC_WAIT;
        end
      end
      smpc_pkg::SMPC_WAIT: begin
        if (lastCyc && startOk) begin
          state_d = smpc_pkg::SMPC_ON;
        end
      end
      smpc_pkg::SMPC_ON: begin
        if (lastCyc) begin
          state_d = startOk ? smpc_pkg::SMPC_ON : smpc_pkg::SMPC_WAIT;
        end else if (!modulationSelect) begin
          if (nextPhase >= fixedPoint) begin
            state_d = smpc_pkg::SMPC_WAIT; // [RULE4]
          end
        end else if (nextPhase >= maxPoint) begin
          state_d = smpc_pkg::SMPC_WAIT; // [RULE23]
        end else if (nextPhase >= minPoint && feedbackFall) begin
          state_d = smpc_pkg::SMPC_WAIT; // [RULE23]
        end
      end
      default: begin
        state_d = smpc_pkg::SMPC_OFF;
      end
    endcase
    if (!moduleEnable) begin
      state_d = smpc_pkg::SMPC_OFF;
    end
  end

  assign pulseActive = (state_d == smpc_pkg::SMPC_ON);

  // Steering flips at every period boundary in dual mode.
  always_comb begin
    toSecond_d = toSecond_q;
    if (!moduleEnable || !outputMode) begin
      toSecond_d = 1'b0;
    end else if (lastCyc) begin
      toSecond_d = !toSecond_q; // [RULE6] [RULE7]
    end
  end

  // Sequencer state, steering and the feedback history.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= smpc_pkg::SMPC_OFF;
      toSecond_q <= 1'b0;
      feedbackPrev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      toSecond_q <= toSecond_d;
      feedbackPrev_q <= feedback;
    end
  end

  // Primary pin: driven while enabled, polarity applied on the way out.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      primaryPulseOut_q <= 1'b0;
      primaryPulseOeN_q <= 1'b1; // [RULE10]
    end else begin
      primaryPulseOeN_q <= !moduleEnable; // [RULE10]
      primaryPulseOut_q <= (pulseActive && !toSecond_d) ^
                           pulseModeControl_q[`SMPC_BIT_POL_A]; // [RULE5] [RULE20]
    end
  end

  // Secondary pin: alternate pulses in dual mode, a pull-low ramp switch otherwise.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      secondaryPulseOut_q <= 1'b0;
      secondaryPulseOeN_q <= 1'b1; // [RULE10]
    end else if (moduleEnable && outputMode) begin
      secondaryPulseOeN_q <= 1'b0; // [RULE19]
      secondaryPulseOut_q <= (pulseActive && toSecond_d) ^
                             pulseModeControl_q[`SMPC_BIT_POL_B]; // [RULE6] [RULE20]
    end else if (moduleEnable && rampSwitchActive && !lastCyc && nextPhase == `SMPC_PH_15) begin
      secondaryPulseOeN_q <= 1'b0; // [RULE8]
      secondaryPulseOut_q <= 1'b0; // [RULE9]
    end else begin
      secondaryPulseOeN_q <= 1'b1; // [RULE19]
      secondaryPulseOut_q <= 1'b0;
    end
  end

  // Register writes; the unimplemented mode bit is never stored.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pulseTimingControl_q <= `SMPC_RST_TIMING;
      pulseModeControl_q <= `SMPC_RST_MODE;
    end else if (regWrite) begin
      if (regAddr == `SMPC_OFS_TIMING) begin
        pulseTimingControl_q <= regWrData;
      end
      if (regAddr == `SMPC_OFS_MODE) begin
        pulseModeControl_q <= regWrData & ~(8'h01 << `SMPC_BIT_UNUSED);
      end
    end
  end

  // Status word shows the live pulse, steering and feedback.
  always_comb begin
    statusWord = `SMPC_READ_ZERO;
    statusWord[`SMPC_STS_ACTIVE] = (state_q == smpc_pkg::SMPC_ON);
    statusWord[`SMPC_STS_SECOND] = toSecond_q;
    statusWord[`SMPC_STS_FEEDBACK] = feedback;
    statusWord[`SMPC_STS_ENABLED] = moduleEnable;
  end

  // Read data stand in the cycle after the strobe and are zero otherwise.
  always_ff @(posedge mclk) begin
    if (!nrst || !regRead) begin
      regRdData_q <= `SMPC_READ_ZERO;
    end else begin
      case (regAddr)
        `SMPC_OFS_TIMING: regRdData_q <= pulseTimingControl_q;
        `SMPC_OFS_MODE: regRdData_q <= pulseModeControl_q;
        `SMPC_OFS_STATUS: regRdData_q <= statusWord;
        default: regRdData_q <= `SMPC_READ_ZERO;
      endcase
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Disabled controller floats both pins from the next edge on.
  float_when_off_a: assert property ( // [RULE10]
    !moduleEnable |=> primaryPulseOeN_q && secondaryPulseOeN_q)
    else $error("Pin driven while controller disabled.");

  // A low sample before the start keeps the skip pulse away.
  skip_low_sample_a: assert property ( // [RULE2]
    moduleEnable && !modulationSelect && lastCyc && !feedback
    |=> state_q != smpc_pkg::SMPC_ON)
    else $error("Skip pulse started on a low sample.");

  // With both inputs selected a low second comparator skips the pulse.
  skip_both_low_a: assert property ( // [RULE3]
    moduleEnable && !modulationSelect && feedbackInputSelect && lastCyc &&
    !secondComparatorResult |=> state_q != smpc_pkg::SMPC_ON)
    else $error("Skip pulse started with second comparator low.");

  // A started skip pulse lasts to the fixed point.
  skip_hold_a: assert property ( // [RULE4]
    moduleEnable && !modulationSelect && state_q == smpc_pkg::SMPC_ON && !lastCyc &&
    nextPhase < fixedPoint |=> state_q == smpc_pkg::SMPC_ON)
    else $error("Skip pulse ended before its fixed duty.");

  // Width mode never holds a pulse past the maximum point.
  width_max_a: assert property ( // [RULE14]
    moduleEnable && modulationSelect && !lastCyc && nextPhase >= maxPoint
    |=> state_q != smpc_pkg::SMPC_ON)
    else $error("Width pulse ran past maximum duty.");

  // Width mode keeps the pulse through the minimum point.
  width_min_a: assert property ( // [RULE13]
    moduleEnable && modulationSelect && state_q == smpc_pkg::SMPC_ON && !lastCyc &&
    nextPhase < minPoint |=> state_q == smpc_pkg::SMPC_ON)
    else $error("Width pulse ended inside minimum duty.");

  // Single mode without the ramp switch leaves the secondary pin free.
  single_release_a: assert property ( // [RULE19]
    moduleEnable && !outputMode && !pulseModeControl_q[`SMPC_BIT_RAMP]
    |=> secondaryPulseOeN_q)
    else $error("Secondary pin driven in plain single mode.");

  // Dual mode never shows both outputs active together.
  dual_exclusive_a: assert property ( // [RULE6] [RULE7]
    moduleEnable && outputMode |=>
    !((primaryPulseOut_q ^ $past(pulseModeControl_q[`SMPC_BIT_POL_A])) &&
      (secondaryPulseOut_q ^ $past(pulseModeControl_q[`SMPC_BIT_POL_B]))))
    else $error("Both outputs active in dual mode.");

  // The ramp switch pulls low in the last sixteenth whatever the polarity.
  ramp_pull_low_a: assert property ( // [RULE8] [RULE9]
    moduleEnable && rampSwitchActive && !lastCyc && nextPhase == `SMPC_PH_15
    |=> !secondaryPulseOeN_q && !secondaryPulseOut_q)
    else $error("Ramp switch missed the last sixteenth.");

  // Timing register reads back what was last written.
  timing_readback_a: assert property (
    regRead && regAddr == `SMPC_OFS_TIMING && !regWrite
    |=> regRdData_q == $past(pulseTimingControl_q))
    else $error("Timing register read back wrong.");

endmodule

// [test/smpc_comparator_model.sv]
// Far side of the pulse controller: the comparator pair and the pin bias networks.
// Assumes the bench commands the comparator decisions at the clock edge.
`timescale 1ns/1ps

module smpc_comparator_model (
  input wire logic lvl1,
  input wire logic lvl2,
  input wire logic outA,
  input wire logic oeNA,
  input wire logic outB,
  input wire logic oeNB,
  output logic cmp1,
  output logic cmp2,
  output logic pinA,
  output logic pinB
);
  // Comparator outputs follow the commanded analog decision at once.
  assign cmp1 = lvl1;
  assign cmp2 = lvl2;
  // Both pins act as outputs; a floating gate line is biased off, the ramp line is pulled up.
  assign pinA = oeNA ? 1'b0 : outA;
  assign pinB = oeNB ? 1'b1 : outB;
endmodule

// [test/smpc_controller_test.sv]
// Self-checking bench of the pulse controller: register port, pulse timing and pins.
// Assumes the comparator model file and the design constant header.
`timescale 1ns/1ps
`include "smpc_cfg.svh"

module smpc_controller_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [`SMPC_ADDR_W-1:0] regAddr = 9'h000;
  logic [`SMPC_DATA_W-1:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [`SMPC_DATA_W-1:0] regRdData_q;
  logic lvl1 = 1'b0;
  logic lvl2 = 1'b0;
  logic polA = 1'b0;
  logic polB = 1'b0;
  logic watchOn = 1'b0;
  logic rdPend = 1'b0;
  logic quiet = 1'b0;
  logic cmp1, cmp2, outA, oeNA, outB, oeNB, pinA, pinB;
  logic [1:0] act;
  logic [1:0] armed = 2'b00;
  logic [8:0] rdQ[$];
  logic [8:0] pulseQ[$];
  logic [7:0] d;
  int wid[2] = '{0, 0};
  int fx[4] = '{2, 6, 10, 15};
  int mx[4] = '{8, 10, 12, 15};
  int badCount = 0;
  int testsRun = 0;
  int seed = 58;
  int ramp;
  int high;

  // Clock of 10 ns period.
  always #5 mclk = ~mclk;

  smpc_controller i_smpc_controller (
    .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData_q(regRdData_q),
    .firstComparatorResult(cmp1), .secondComparatorResult(cmp2),
    .primaryPulseOut_q(outA), .primaryPulseOeN_q(oeNA),
    .secondaryPulseOut_q(outB), .secondaryPulseOeN_q(oeNB)
  );

  smpc_comparator_model i_smpc_comparator_model (
    .lvl1(lvl1), .lvl2(lvl2), .outA(outA), .oeNA(oeNA), .outB(outB), .oeNB(oeNB),
    .cmp1(cmp1), .cmp2(cmp2), .pinA(pinA), .pinB(pinB)
  );

  // Compares one result with its expectation and counts both outcomes.
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One write cycle, then one quiet cycle on the register port.
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    @(posedge mclk);
  endtask

  // One read cycle; the expected data are noted in the read queue.
  task automatic rd(input logic [8:0] a, input logic [7:0] v);
    rdQ.push_back({1'b0, v});
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(posedge mclk);
  endtask

  // Stops the controller before the divider changes, then applies the new setup.
  task automatic cfg(input logic [7:0] t, input logic [7:0] m);
    wr(`SMPC_OFS_MODE, m & 8'h7F);
    wr(`SMPC_OFS_TIMING, t);
    wr(`SMPC_OFS_MODE, m);
  endtask

  // Notes a number of expected pulses, each as pin and width in cycles.
  task automatic note(input logic [8:0] e, input int n);
    repeat (n) pulseQ.push_back(e);
  endtask

  // Opens the watch and waits, bounded, until every noted pulse has shown.
  task automatic drain();
    int k;
    k = 0;
    watchOn <= 1'b1;
    while (pulseQ.size() != 0 && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    watchOn <= 1'b0;
    @(posedge mclk);
    $display("pulse test ended at %0t ns", $time);
    if (pulseQ.size() != 0) begin
      badCount++;
      $display("wait limit reached at %0t ns", $time);
      conclude();
    end
  endtask

  // Watches for a while during which no pulse may appear.
  task automatic idle(input int n);
    watchOn <= 1'b1;
    quiet <= 1'b1;
    repeat (n) @(posedge mclk);
    watchOn <= 1'b0;
    quiet <= 1'b0;
    @(posedge mclk);
    $display("quiet test ended at %0t ns", $time);
  endtask

  // Waits, bounded, for the edge that shows a fresh primary pulse.
  task automatic waitRise();
    int k;
    logic was;
    k = 0;
    do begin
      was = pinA;
      @(posedge mclk);
      k++;
    end while (!(pinA === 1'b1 && was === 1'b0) && k < 300);
    if (k >= 300) begin
      badCount++;
      $display("rise limit reached at %0t ns", $time);
      conclude();
    end
  endtask

  // Drops the feedback for one cycle a set number of cycles into a pulse.
  task automatic fallAt(input logic [7:0] t, input logic [7:0] m, input int dly,
                        input logic [8:0] w, input logic [8:0] w2);
    lvl1 <= 1'b1;
    cfg(t, m);
    pulseQ.push_back(w);
    pulseQ.push_back(w2);
    watchOn <= 1'b1;
    waitRise();
    repeat (dly) @(posedge mclk);
    lvl1 <= 1'b0;
    @(posedge mclk);
    lvl1 <= 1'b1;
    drain();
  endtask

  // Read data stand in the cycle after the strobe; the oldest note is compared then.
  always @(posedge mclk) begin
    if (rdPend) begin
      check({1'b0, regRdData_q}, rdQ.size() != 0 ? rdQ.pop_front() : 9'h1FF);
    end
    rdPend <= regRead;
  end

  // Measures each active run on both pins and compares it with the oldest pulse note.
  always @(posedge mclk) begin
    act = {!oeNB && (pinB ^ polB), !oeNA && (pinA ^ polA)};
    for (int p = 0; p < 2; p++) begin
      if (act[p]) begin
        // A run that starts after the last note is only judged inside a quiet watch.
        if (wid[p] == 0) armed[p] = watchOn && (pulseQ.size() != 0 || quiet);
        wid[p]++;
      end else if (wid[p] != 0) begin
        if (armed[p]) check({p[0], wid[p][7:0]}, pulseQ.size() != 0 ? pulseQ.pop_front() : 9'h000);
        wid[p] = 0;
      end
    end
  end

  // Main sequence: reset, registers, then each pulse behaviour in turn.
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    check({7'h00, oeNA, oeNB}, 9'h003);
    rd(`SMPC_OFS_TIMING, `SMPC_RST_TIMING);
    rd(`SMPC_OFS_MODE, `SMPC_RST_MODE);
    d = 8'($random(seed));
    wr(`SMPC_OFS_TIMING, d);
    rd(`SMPC_OFS_TIMING, d);
    wr(`SMPC_OFS_MODE, d & 8'h7F);
    rd(`SMPC_OFS_MODE, d & 8'h6F);
    wr(9'h110, d);
    rd(9'h110, `SMPC_READ_ZERO);
    check({7'h00, oeNA, oeNB}, 9'h003);
    $display("register test ended at %0t ns", $time);
    lvl1 <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      cfg({c[1:0], 6'h00}, 8'h80);
      note(9'(16 >> c), 2);
      drain();
    end
    for (int c = 0; c < 4; c++) begin
      cfg({6'h30, c[1:0]}, 8'h80);
      note(9'(fx[c]), 2);
      drain();
    end
    check({7'h00, oeNA, oeNB}, 9'h001);
    lvl1 <= 1'b0;
    idle(64);
    cfg(8'hC0, 8'h81);
    lvl1 <= 1'b1;
    idle(64);
    lvl2 <= 1'b1;
    note(9'h002, 2);
    drain();
    fallAt(8'hC2, 8'h80, 0, 9'h00A, 9'h00A);
    polA <= 1'b1;
    cfg(8'hC0, 8'hC0);
    note(9'h002, 2);
    drain();
    polA <= 1'b0;
    polB <= 1'b1;
    cfg(8'hC3, 8'hAC);
    // Steering flips at the first period end, so the secondary pin leads.
    repeat (2) begin
      note(9'h10F, 1);
      note(9'h00F, 1);
    end
    drain();
    polB <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      cfg({4'hC, c[1:0], 2'b00}, 8'h82);
      note(9'(mx[c]), 2);
      drain();
    end
    lvl1 <= 1'b0;
    idle(64);
    fallAt(8'hFC, 8'h82, 0, 9'h00F, 9'h00F);
    fallAt(8'hDC, 8'h82, 3, 9'h005, 9'h00F);
    cfg(8'hC0, 8'hA8);
    ramp = 0;
    high = 0;
    repeat (64) begin
      @(posedge mclk);
      if (oeNB === 1'b0 && outB === 1'b0) ramp++;
      if (oeNB === 1'b0 && outB !== 1'b0) high++;
    end
    check(9'(ramp), 9'h004);
    check(9'(high), 9'h000);
    $display("ramp test ended at %0t ns", $time);
    wr(`SMPC_OFS_MODE, 8'h00);
    idle(64);
    rd(`SMPC_OFS_STATUS, 8'h04);
    cfg(8'hC0, 8'h80);
    repeat (20) @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    check({7'h00, oeNA, oeNB}, 9'h003);
    rd(`SMPC_OFS_MODE, `SMPC_RST_MODE);
    $display("reset test ended at %0t ns", $time);
    conclude();
  end
endmodule
